//--- design/pwm_counter_pkg.sv
// constants, register map and types for the multi-channel pwm timer counter block
// assumes an apb master with 32-bit data and one 100 mhz clock
package pwm_counter_pkg;
    localparam int          CLK_MHZ         = 100;
    localparam int          NUM_CHANNELS    = 3;
    localparam int          EVENT_CHANNEL   = 1;
    localparam int          DUMMY_EDGES     = 2;
    localparam logic [11:0] CH_STRIDE       = 12'h020;
    localparam logic [4:0]  OFF_CLOCK       = 5'h00;
    localparam logic [4:0]  OFF_CONTROL     = 5'h04;
    localparam logic [4:0]  OFF_MAX         = 5'h08;
    localparam logic [4:0]  OFF_COUNT       = 5'h0C;
    localparam logic [11:0] OFF_INT_STATUS  = 12'h080;
    localparam logic [11:0] OFF_INT_MASK    = 12'h084;
    localparam logic [11:0] OFF_PIN_MODE    = 12'h088;
    // clock register fields
    localparam int          CLK_SRC_LSB     = 0;
    localparam int          CLK_DIV_LSB     = 4;
    localparam int          CLK_DBG_BIT     = 8;
    localparam int          CLK_SLEEP_BIT   = 9;
    // control register fields
    localparam int          CTL_RUN_BIT     = 0;
    localparam int          CTL_PRESET_BIT  = 1;
    localparam int          CTL_DIR_LSB     = 4;
    localparam int          CTL_ONE_BIT     = 6;
    localparam int          CTL_BUSY_BIT    = 8;
    localparam int          CTL_UP_BIT      = 9;
    localparam int          CTL_MAXP_BIT    = 10;
    localparam logic [15:0] MAX_RESET       = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO      = 16'h0000;
    localparam logic [2:0]  SRC_SYSTEM      = 3'h0;
    localparam logic [2:0]  SRC_EXT         = 3'h6;
    localparam logic [2:0]  SRC_EXT_INV     = 3'h7;
    // interrupt bit positions per channel: wrap, one-shot stop
    localparam int          IRQ_PER_CH      = 2;

    typedef enum logic [1:0] {
        DIR_UP     = 2'b00,
        DIR_DOWN   = 2'b01,
        DIR_UPDOWN = 2'b10
    } count_dir_t;

    typedef struct packed {
        logic        debug_keep_running;
        logic        sleep_source_stop;
        logic [3:0]  count_divider_select;
        logic [2:0]  count_source_select;
    } clock_cfg_t;

    typedef struct packed {
        logic        run;
        logic        single_cycle_select;
        count_dir_t  count_direction_field;
        logic        counting_up;
        logic        max_write_pending;
        logic [1:0]  ext_dummy;
        logic        ext_prev;
        logic [14:0] prescale;
        logic [15:0] max_value;
        logic [15:0] counter_value;
    } channel_t;
endpackage : pwm_counter_pkg

//--- design/pwm_timer_counter_block.sv
// counter section of a three channel pwm timer, registers on apb
// assumes debug halt and sleep levels synchronous to clk_in; count clock as enable pulses
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ns

// Functional notes
// - each channel has a 16-bit up/down counter stepping on its count clock
// - count clock from 3-bit source select, divided by 4-bit divider select
// - debug-run 0 freezes count clock during debug halt, state held
// - debug-run 1 keeps the channel counting during debug halt
// - sleep-stop 1 freezes channel in sleep, resumes after wake
// - external source counts rising edges, inverted source counts falling edges
// - two-bit direction plus one-shot bit give six counter modes
// - repeat modes run until stopped; one-shot stops after one cycle
// - max value register bounds count range 0x0000 to max
// - preset clears to 0x0000 in up or up/down, loads max in down
// - counting up past max clears the counter to 0x0000
// - run bit 1 starts counting; stop follows repeat or one-shot mode
// - three channels, only channel 1 takes the external event clock
// - channel pin is output low in compare mode, capture input otherwise
module pwm_timer_counter_block #(
    parameter int NUM_CH = pwm_counter_pkg::NUM_CHANNELS
) (
    input  wire logic                clk_in,
    input  wire logic                rst_in,
    input  wire logic                psel_in,
    input  wire logic                penable_in,
    input  wire logic                pwrite_in,
    input  wire logic [11:0]         paddr_in,
    input  wire logic [31:0]         pwdata_in,
    output logic      [31:0]         prdata_out,
    output logic                     pready_out,
    output logic                     pslverr_out,
    input  wire logic                debug_halt_in,
    input  wire logic                sleep_in,
    input  wire logic [7:0]          source_tick_in,
    input  wire logic                external_count_input_in,
    input  wire logic [NUM_CH-1:0]   capture_trigger_pin_in,
    output logic      [NUM_CH-1:0]   timer_output_pin_out,
    output logic      [NUM_CH-1:0]   timer_output_pin_oe_out,
    output logic      [NUM_CH-1:0]   count_tick_out,
    output logic                     irq_out
);
    localparam int IRQ_W = NUM_CH * pwm_counter_pkg::IRQ_PER_CH;

    typedef struct packed {
        pwm_counter_pkg::channel_t   [NUM_CH-1:0] ch;
        pwm_counter_pkg::clock_cfg_t [NUM_CH-1:0] clk;
        logic [IRQ_W-1:0]  status;
        logic [IRQ_W-1:0]  mask;
        logic [NUM_CH-1:0] capture_mode;
        logic [NUM_CH-1:0] tick;
        logic [31:0]       rdata;
    } state_t;

    state_t state;
    state_t next_state;
    logic   access;
    logic   wr;
    logic   rd;
    logic   mapped;

    // divider ratio 1,2,4 .. 32768 as prescale terminal count
    function automatic logic [14:0] div_limit(input logic [3:0] sel);
        div_limit = 15'((32'h1 << sel) - 32'h1);
    endfunction : div_limit

    function automatic logic ch_reg_hit(input logic [11:0] a, input int c, input logic [4:0] o);
        ch_reg_hit = (a == 12'(c * 32) + 12'(o));
    endfunction : ch_reg_hit

    assign access      = psel_in && penable_in;
    assign wr          = access && pwrite_in;
    assign rd          = psel_in && !penable_in && !pwrite_in;  // setup read: data ready at access
    assign pready_out  = 1'b1;
    assign pslverr_out = access && !mapped;
    assign prdata_out  = state.rdata;
    assign irq_out     = |(state.status & state.mask);
    assign count_tick_out = state.tick;

    // pin idles as output driven low; compare waveform lives outside this block
    assign timer_output_pin_out    = '0;
    assign timer_output_pin_oe_out = ~state.capture_mode;

    always_comb begin
        logic        src_tick, ext_lvl, step, gated, wrapped, stopped;
        logic [15:0] cnt, mx;
        next_state = state;
        src_tick   = 1'b0;
        ext_lvl    = 1'b0;
        step       = 1'b0;
        gated      = 1'b0;
        wrapped    = 1'b0;
        stopped    = 1'b0;
        cnt        = 16'h0000;
        mx         = 16'h0000;
        next_state.tick = '0;
        mapped     = (paddr_in == pwm_counter_pkg::OFF_INT_STATUS) ||
                     (paddr_in == pwm_counter_pkg::OFF_INT_MASK) ||
                     (paddr_in == pwm_counter_pkg::OFF_PIN_MODE);
        // clear only what the setup read returned; events set below still win
        if (access && !pwrite_in && paddr_in == pwm_counter_pkg::OFF_INT_STATUS) begin
            next_state.status = state.status & ~state.rdata[IRQ_W-1:0];
        end
        for (int c = 0; c < NUM_CH; c++) begin
            // max-pending holds one cycle after a max write lands
            next_state.ch[c].max_write_pending = 1'b0;
            // source select: external only on the event channel
            if (c == pwm_counter_pkg::EVENT_CHANNEL &&
                state.clk[c].count_source_select >= pwm_counter_pkg::SRC_EXT) begin
                ext_lvl = external_count_input_in;
                if (state.clk[c].count_source_select == pwm_counter_pkg::SRC_EXT_INV) begin
                    ext_lvl = !external_count_input_in;
                end
                src_tick = ext_lvl && !state.ch[c].ext_prev;
                next_state.ch[c].ext_prev = ext_lvl;
            end else begin
                src_tick = source_tick_in[state.clk[c].count_source_select];
            end
            gated = (debug_halt_in && !state.clk[c].debug_keep_running) ||
                    (sleep_in && state.clk[c].sleep_source_stop);
            step = 1'b0;
            if (src_tick && !gated) begin
                if (state.ch[c].prescale >= div_limit(state.clk[c].count_divider_select)) begin
                    next_state.ch[c].prescale = '0;
                    step = 1'b1;
                end else begin
                    next_state.ch[c].prescale = state.ch[c].prescale + 15'h0001;
                end
            end
            // external events: first two count steps after the divider only prime the counter
            if (step && c == pwm_counter_pkg::EVENT_CHANNEL &&
                state.clk[c].count_source_select >= pwm_counter_pkg::SRC_EXT &&
                state.ch[c].ext_dummy < 2'(pwm_counter_pkg::DUMMY_EDGES)) begin
                next_state.ch[c].ext_dummy = state.ch[c].ext_dummy + 2'h1;
                step = 1'b0;
            end
            next_state.tick[c] = step && state.ch[c].run;
            cnt     = state.ch[c].counter_value;
            mx      = state.ch[c].max_value;
            wrapped = 1'b0;
            stopped = 1'b0;
            if (step && state.ch[c].run) begin
                unique case (state.ch[c].count_direction_field)
                    pwm_counter_pkg::DIR_DOWN: begin
                        next_state.ch[c].counting_up = 1'b0;
                        if (cnt == 16'h0000) begin
                            next_state.ch[c].counter_value = mx;
                            wrapped = 1'b1;
                        end else begin
                            next_state.ch[c].counter_value = cnt - 16'h0001;
                        end
                    end
                    pwm_counter_pkg::DIR_UPDOWN: begin
                        if (state.ch[c].counting_up) begin
                            if (cnt >= mx) begin
                                next_state.ch[c].counting_up   = 1'b0;
                                next_state.ch[c].counter_value = (cnt > mx) ? 16'h0000 :
                                                                 cnt - 16'h0001;
                            end else begin
                                next_state.ch[c].counter_value = cnt + 16'h0001;
                            end
                        end else if (cnt == 16'h0000) begin
                            next_state.ch[c].counting_up   = 1'b1;
                            next_state.ch[c].counter_value = 16'h0001;
                            wrapped = 1'b1;
                            if (state.ch[c].single_cycle_select) begin
                                next_state.ch[c].counter_value = 16'h0000;
                            end
                        end else begin
                            next_state.ch[c].counter_value = cnt - 16'h0001;
                        end
                    end
                    default: begin
                        next_state.ch[c].counting_up = 1'b1;
                        if (cnt >= mx) begin
                            next_state.ch[c].counter_value = pwm_counter_pkg::COUNT_ZERO;
                            wrapped = 1'b1;
                        end else begin
                            next_state.ch[c].counter_value = cnt + 16'h0001;
                        end
                    end
                endcase
                if (wrapped && state.ch[c].single_cycle_select) begin
                    next_state.ch[c].run = 1'b0;
                    stopped = 1'b1;
                end
            end
            if (wrapped) begin
                next_state.status[c * 2] = 1'b1;
            end
            if (stopped) begin
                next_state.status[c * 2 + 1] = 1'b1;
            end
            if (ch_reg_hit(paddr_in, c, pwm_counter_pkg::OFF_CLOCK) ||
                ch_reg_hit(paddr_in, c, pwm_counter_pkg::OFF_CONTROL) ||
                ch_reg_hit(paddr_in, c, pwm_counter_pkg::OFF_MAX) ||
                ch_reg_hit(paddr_in, c, pwm_counter_pkg::OFF_COUNT)) begin
                mapped = 1'b1;
            end
            if (wr && ch_reg_hit(paddr_in, c, pwm_counter_pkg::OFF_CLOCK)) begin
                next_state.clk[c] = {pwdata_in[pwm_counter_pkg::CLK_DBG_BIT],
                                     pwdata_in[pwm_counter_pkg::CLK_SLEEP_BIT],
                                     pwdata_in[pwm_counter_pkg::CLK_DIV_LSB +: 4],
                                     pwdata_in[pwm_counter_pkg::CLK_SRC_LSB +: 3]};
                next_state.ch[c].ext_prev = external_count_input_in ^
                    (pwdata_in[pwm_counter_pkg::CLK_SRC_LSB +: 3] == pwm_counter_pkg::SRC_EXT_INV);
                next_state.ch[c].ext_dummy = 2'h0;
                next_state.ch[c].prescale  = '0;
            end
            if (wr && ch_reg_hit(paddr_in, c, pwm_counter_pkg::OFF_MAX)) begin
                next_state.ch[c].max_value         = pwdata_in[15:0];
                next_state.ch[c].max_write_pending = 1'b1;
            end
            if (wr && ch_reg_hit(paddr_in, c, pwm_counter_pkg::OFF_CONTROL)) begin
                next_state.ch[c].run = pwdata_in[pwm_counter_pkg::CTL_RUN_BIT];
                next_state.ch[c].single_cycle_select =
                    pwdata_in[pwm_counter_pkg::CTL_ONE_BIT];
                next_state.ch[c].count_direction_field = pwm_counter_pkg::count_dir_t'(
                    pwdata_in[pwm_counter_pkg::CTL_DIR_LSB +: 2]);
                if (pwdata_in[pwm_counter_pkg::CTL_PRESET_BIT]) begin
                    if (pwm_counter_pkg::count_dir_t'(pwdata_in[pwm_counter_pkg::CTL_DIR_LSB +: 2])
                        == pwm_counter_pkg::DIR_DOWN) begin
                        next_state.ch[c].counter_value = state.ch[c].max_value;
                        next_state.ch[c].counting_up   = 1'b0;
                    end else begin
                        next_state.ch[c].counter_value = pwm_counter_pkg::COUNT_ZERO;
                        next_state.ch[c].counting_up   = 1'b1;
                    end
                end
            end
            if (rd && ch_reg_hit(paddr_in, c, pwm_counter_pkg::OFF_CLOCK)) begin
                next_state.rdata = {22'h000000, state.clk[c].sleep_source_stop,
                                    state.clk[c].debug_keep_running,
                                    state.clk[c].count_divider_select, 1'b0,
                                    state.clk[c].count_source_select};
            end
            if (rd && ch_reg_hit(paddr_in, c, pwm_counter_pkg::OFF_CONTROL)) begin
                next_state.rdata = {21'h000000, state.ch[c].max_write_pending,
                                    state.ch[c].counting_up, state.ch[c].run, 1'b0,
                                    state.ch[c].single_cycle_select,
                                    state.ch[c].count_direction_field, 3'h0,
                                    state.ch[c].run};
            end
            if (rd && ch_reg_hit(paddr_in, c, pwm_counter_pkg::OFF_MAX)) begin
                next_state.rdata = {16'h0000, state.ch[c].max_value};
            end
            if (rd && ch_reg_hit(paddr_in, c, pwm_counter_pkg::OFF_COUNT)) begin
                next_state.rdata = {16'h0000, state.ch[c].counter_value};
            end
        end
        if (rd && paddr_in == pwm_counter_pkg::OFF_INT_STATUS) begin
            next_state.rdata  = 32'(state.status);
        end
        if (rd && paddr_in == pwm_counter_pkg::OFF_INT_MASK) begin
            next_state.rdata = 32'(state.mask);
        end
        if (rd && paddr_in == pwm_counter_pkg::OFF_PIN_MODE) begin
            next_state.rdata = 32'(state.capture_mode);
        end
        if (wr && paddr_in == pwm_counter_pkg::OFF_INT_MASK) begin
            next_state.mask = pwdata_in[IRQ_W-1:0];
        end
        if (wr && paddr_in == pwm_counter_pkg::OFF_PIN_MODE) begin
            next_state.capture_mode = pwdata_in[NUM_CH-1:0];
        end
        if (rd && !mapped) begin
            next_state.rdata = 32'h00000000;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= '0;
            for (int c = 0; c < NUM_CH; c++) begin
                state.ch[c].max_value   <= pwm_counter_pkg::MAX_RESET;
                state.ch[c].counting_up <= 1'b1;
            end
        end else begin
            state <= next_state;
        end
    end

    property p_up_wrap;
        @(posedge clk_in) disable iff (rst_in)
        (state.ch[0].run && state.tick[0] == 1'b0 && next_state.tick[0] &&
         state.ch[0].count_direction_field == pwm_counter_pkg::DIR_UP &&
         state.ch[0].counter_value >= state.ch[0].max_value && !wr)
        |=> state.ch[0].counter_value == 16'h0000;
    endproperty
    a_up_wrap: assert property (p_up_wrap) else $error("up count did not wrap to zero");

    property p_halt_hold;
        @(posedge clk_in) disable iff (rst_in)
        (!state.ch[0].run && !wr) |=> $stable(state.ch[0].counter_value);
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("stopped counter moved");

    property p_debug_freeze;
        @(posedge clk_in) disable iff (rst_in)
        (debug_halt_in && !state.clk[0].debug_keep_running) |-> !next_state.tick[0];
    endproperty
    a_debug_freeze: assert property (p_debug_freeze) else $error("counted in debug halt");

    property p_sleep_freeze;
        @(posedge clk_in) disable iff (rst_in)
        (sleep_in && state.clk[0].sleep_source_stop && !wr)
        |=> $stable(state.ch[0].counter_value);
    endproperty
    a_sleep_freeze: assert property (p_sleep_freeze) else $error("counted during sleep");

    property p_one_shot_stop;
        @(posedge clk_in) disable iff (rst_in)
        ($fell(state.ch[0].run) && !$past(wr)) |-> state.ch[0].single_cycle_select;
    endproperty
    a_one_shot_stop: assert property (p_one_shot_stop) else $error("repeat mode stopped");

    property p_preset_down;
        @(posedge clk_in) disable iff (rst_in)
        (wr && paddr_in == pwm_counter_pkg::OFF_CONTROL &&
         pwdata_in[pwm_counter_pkg::CTL_PRESET_BIT] &&
         pwdata_in[pwm_counter_pkg::CTL_DIR_LSB +: 2] == 2'b01)
        |=> state.ch[0].counter_value == $past(state.ch[0].max_value);
    endproperty
    a_preset_down: assert property (p_preset_down) else $error("down preset missed max");

    property p_irq_level;
        @(posedge clk_in) disable iff (rst_in)
        (state.status[0] && state.mask[0] && !access) |=> irq_out;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level mismatch");

    property p_pin_low;
        @(posedge clk_in) disable iff (rst_in)
        !state.capture_mode[0] |-> (timer_output_pin_oe_out[0] && !timer_output_pin_out[0]);
    endproperty
    a_pin_low: assert property (p_pin_low) else $error("pin not driven low");
endmodule : pwm_timer_counter_block

//--- sim/pwm_timer_counter_block_tb_top.sv
// self-checking bench for the pwm timer counter block, apb master in tasks
// assumes read data and pready stand at the access edge of each transfer
`timescale 1ns/1ns
module pwm_timer_counter_block_tb_top;
    localparam logic [11:0] CK = 12'h000;
    localparam logic [11:0] CT = 12'h004;
    localparam logic [11:0] MX = 12'h008;
    localparam logic [11:0] CN = 12'h00C;
    logic        clk_in      = 1'b0;
    logic        rst_in      = 1'b1;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [11:0] paddr       = 12'h000;
    logic [31:0] pwdata      = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] q;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic        halt        = 1'b0;
    logic        slp         = 1'b0;
    logic        ext         = 1'b0;
    logic        irq;
    logic [7:0]  src         = 8'h00;
    logic [2:0]  cap         = 3'h0;
    logic [2:0]  pin;
    logic [2:0]  oe;
    int          fail_count  = 0;
    int          comparisons = 0;
    int          cyc         = 0;

    pwm_timer_counter_block DUT (
        .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .debug_halt_in(halt), .sleep_in(slp),
        .source_tick_in(src), .external_count_input_in(ext), .capture_trigger_pin_in(cap),
        .timer_output_pin_out(pin), .timer_output_pin_oe_out(oe), .count_tick_out(),
        .irq_out(irq));

    initial begin
        forever #5 clk_in = ~clk_in;
    end

    // run is a few hundred cycles; ceiling leaves wide margin
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic close_out();
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        // request holds until pready is seen high; only the bench timeout ends a hang
        do begin
            @(posedge clk_in);
        end while (pready !== 1'b1);
        err = pslverr;
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        check(q & m, e);
    endtask : rd

    task automatic tick(input int n, input int b);
        repeat (n) begin
            @(posedge clk_in);
            src <= 8'h01 << b;
            @(posedge clk_in);
            src <= 8'h00;
            repeat (2) @(posedge clk_in);
        end
    endtask : tick

    task automatic edges(input int n);
        repeat (n) begin
            repeat (3) @(posedge clk_in);
            ext <= ~ext;
        end
    endtask : edges

    function automatic logic [31:0] cw(input logic [1:0] d, input logic o, p, r);
        return (32'(d) << 4) | (32'(o) << 6) | (32'(p) << 1) | 32'(r);
    endfunction : cw

    task automatic t_reset();
        rd(MX, 32'h0000_FFFF, 32'h0000_FFFF);
        rd(CN, 32'h0000_FFFF, 32'h0000_0000);
        check(32'(oe), 32'h0000_0007);
        check(32'(pin), 32'h0000_0000);
    endtask : t_reset

    task automatic t_repeat();
        wr(MX, 32'h0000_0003);
        wr(CT, cw(2'h0, 1'b0, 1'b0, 1'b1));
        tick(5, 0);
        wr(CT, cw(2'h0, 1'b0, 1'b0, 1'b0));
        rd(CN, 32'h0000_FFFF, 32'h0000_0001);
        tick(3, 0);
        rd(CN, 32'h0000_FFFF, 32'h0000_0001);
        wr(CT, cw(2'h1, 1'b0, 1'b1, 1'b0));
        rd(CN, 32'h0000_FFFF, 32'h0000_0003);
        wr(CT, cw(2'h1, 1'b0, 1'b0, 1'b1));
        tick(5, 0);
        wr(CT, cw(2'h1, 1'b0, 1'b0, 1'b0));
        rd(CN, 32'h0000_FFFF, 32'h0000_0002);
        wr(CT, cw(2'h0, 1'b0, 1'b1, 1'b0));
        rd(CN, 32'h0000_FFFF, 32'h0000_0000);
    endtask : t_repeat

    task automatic t_oneshot();
        for (int d = 0; d < 3; d++) begin
            wr(CT, cw(2'(d), 1'b1, 1'b1, 1'b0));
            wr(CT, cw(2'(d), 1'b1, 1'b0, 1'b1));
            tick(10, 0);
            rd(CN, 32'h0000_FFFF, (d == 1) ? 32'h0000_0003 : 32'h0000_0000);
            rd(CT, 32'h0000_0101, 32'h0000_0000);
        end
    endtask : t_oneshot

    task automatic t_gating();
        wr(MX, 32'h0000_FFFF);
        wr(CK, 32'h0000_0000);
        wr(CT, cw(2'h0, 1'b0, 1'b1, 1'b1));
        halt <= 1'b1;
        tick(3, 0);
        rd(CN, 32'h0000_FFFF, 32'h0000_0000);
        wr(CK, 32'h0000_0100);
        tick(3, 0);
        rd(CN, 32'h0000_FFFF, 32'h0000_0003);
        halt <= 1'b0;
        slp <= 1'b1;
        wr(CK, 32'h0000_0200);
        tick(3, 0);
        rd(CN, 32'h0000_FFFF, 32'h0000_0003);
        slp <= 1'b0;
        tick(2, 0);
        rd(CN, 32'h0000_FFFF, 32'h0000_0005);
        // source 3, divide by four; ticks of source 0 must not count
        wr(CK, 32'h0000_0023);
        wr(CT, cw(2'h0, 1'b0, 1'b1, 1'b1));
        tick(8, 3);
        tick(4, 0);
        rd(CN, 32'h0000_FFFF, 32'h0000_0002);
        rd(CN, 32'h0000_FFFF, 32'h0000_0002);
    endtask : t_gating

    task automatic t_external();
        wr(12'h020 | MX, 32'h0000_FFFF);
        wr(12'h020 | CK, 32'h0000_0006);
        wr(12'h020 | CT, cw(2'h0, 1'b0, 1'b1, 1'b1));
        wr(CK, 32'h0000_0006);
        wr(CT, cw(2'h0, 1'b0, 1'b1, 1'b1));
        // seven toggles: four rising, three falling edges
        edges(7);
        rd(12'h020 | CN, 32'h0000_FFFF, 32'h0000_0002);
        rd(CN, 32'h0000_FFFF, 32'h0000_0000);
        wr(12'h020 | CK, 32'h0000_0007);
        wr(12'h020 | CT, cw(2'h0, 1'b0, 1'b1, 1'b1));
        edges(7);
        rd(12'h020 | CN, 32'h0000_FFFF, 32'h0000_0002);
    endtask : t_external

    task automatic t_irq();
        wr(MX, 32'h0000_0001);
        wr(CK, 32'h0000_0000);
        apb(1'b0, 12'h080, 32'h0000_0000);
        wr(12'h084, 32'h0000_0001);
        wr(CT, cw(2'h0, 1'b0, 1'b1, 1'b1));
        tick(2, 0);
        check(32'(irq), 32'h0000_0001);
        rd(12'h080, 32'h0000_0001, 32'h0000_0001);
        @(posedge clk_in);
        check(32'(irq), 32'h0000_0000);
        wr(12'h084, 32'h0000_0000);
        tick(2, 0);
        check(32'(irq), 32'h0000_0000);
        rd(12'h080, 32'h0000_0001, 32'h0000_0001);
        rd(CT, 32'h0000_0400, 32'h0000_0000);
        wr(MX, 32'h0000_0003);
        tick(3, 0);
        rd(CN, 32'h0000_FFFF, 32'h0000_0003);
        rd(12'h0FC, 32'hFFFF_FFFF, 32'h0000_0000);
        check(32'(err), 32'h0000_0001);
    endtask : t_irq

    initial begin
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_repeat();
        t_oneshot();
        t_gating();
        t_external();
        t_irq();
        close_out();
    end
endmodule : pwm_timer_counter_block_tb_top
